/* File: design/sgs_consts.svh */
// Constants for the servo gain group switcher
`ifndef SGS_CONSTS_SVH
`define SGS_CONSTS_SVH

// Selector codes
`define SGS_SEL_FIXED_FIRST 3'h0
`define SGS_SEL_FIXED_SECOND 3'h1
`define SGS_SEL_INPUT 3'h2
`define SGS_SEL_FREQ 3'h3
`define SGS_SEL_DEVIATION 3'h4
`define SGS_SEL_SPEED 3'h5

// Setting defaults, for whoever drives the setting ports
`define SGS_SEL_DEF 3'h0
`define SGS_LEVEL_DEF 15'h0064
`define SGS_HYST_DEF 15'h0005
`define SGS_DELAY_DEF 12'h005
`define SGS_RAMP_DEF 12'h005

// Upper limit of delay and ramp settings, in ms
`define SGS_TIME_MAX 12'hbb8

// Integral time in 0.1 ms units that cancels the integral term
`define SGS_INTEG_MAX 16'h2710

// Millisecond tick: time in us and clock rate in kHz
`define SGS_TICK_TIME_US 32'h3e8
`define SGS_CLK_FREQ_KHZ 32'h2710
`define SGS_TICK_CYCLES ((`SGS_TICK_TIME_US * `SGS_CLK_FREQ_KHZ) / 32'h3e8)

// Gain lanes per group
`define SGS_LANES 4
`define SGS_LANE_SPEED 0
`define SGS_LANE_INTEG 1
`define SGS_LANE_FILTER 2
`define SGS_LANE_POS 3

`endif

/* File: design/sgs_gain_switch.sv */
// Servo gain group switcher: condition, qualification and linear ramp
//
// Operation
// - Selector 0 keeps first group always; selector range 0 to 5, default 0.
// - Selector 1 keeps second group always, whatever the inputs.
// - Selector 2 follows group select input: off first, on second.
// - Selector 3 goes second when command pulse frequency exceeds level.
// - Selector 4 goes second when position deviation exceeds level.
// - Selector 5 goes second when motor speed exceeds level.
// - Level setting spans 0 to 32767, default 100, shared by modes 3-5.
// - Return to first group once the active condition no longer holds.
// - Change applies only after condition persists for qualify delay ms.
// - Gains move linearly to the target group over ramp time ms.
// - All four gains ramp together, starting and ending at once.
// - Comparison uses a hysteresis band, 0 to 32767, default 5.
// - Integral time at 1000.0 means the integral term is cancelled.
// - Each group holds speed gain, integral, filter and position gain.
`timescale 1ns/1ps
`default_nettype none
`include "sgs_consts.svh"

module sgs_gain_switch #(
  parameter int MS_CYCLES = `SGS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  // Switching settings
  input wire logic [2:0] GAIN_SWITCH_SELECT_I,
  input wire logic [14:0] SWITCH_THRESHOLD_LEVEL_I,
  input wire logic [14:0] SWITCH_HYSTERESIS_I,
  input wire logic [11:0] SWITCH_QUALIFY_DELAY_I,
  input wire logic [11:0] SWITCH_RAMP_TIME_I,
  // Switching sources
  input wire logic GROUP_SELECT_INPUT_I,
  input wire logic [15:0] CMD_PULSE_FREQ_I,
  input wire logic signed [31:0] POS_DEVIATION_I,
  input wire logic signed [15:0] MOTOR_SPEED_I,
  // First gain group
  input wire logic [15:0] SPEED_GAIN_1_I,
  input wire logic [15:0] INTEGRAL_TIME_1_I,
  input wire logic [15:0] TORQUE_FILTER_1_I,
  input wire logic [15:0] POSITION_GAIN_1_I,
  // Second gain group
  input wire logic [15:0] SPEED_GAIN_2_I,
  input wire logic [15:0] SECOND_INTEGRAL_TIME_I,
  input wire logic [15:0] TORQUE_FILTER_2_I,
  input wire logic [15:0] POSITION_GAIN_2_I,
  // Gains applied to the control loops
  output logic [15:0] SPEED_GAIN_O,
  output logic [15:0] INTEGRAL_TIME_O,
  output logic [15:0] TORQUE_FILTER_O,
  output logic [15:0] POSITION_GAIN_O,
  output logic INTEGRAL_CANCEL_O,
  // Switch status
  output logic ACTIVE_GROUP_O,
  output logic SWITCH_PENDING_O,
  output logic RAMP_BUSY_O,
  output logic CONDITION_MET_O
);
  sgs_pkg::sgs_ctl_t s_r;
  sgs_pkg::sgs_ctl_t s_nxt;
  sgs_ramp_if ramp ();

  logic ms_tick;
  logic want;
  logic cmp_want;
  logic pending;
  logic qualified;
  logic qual_step;
  logic ramp_zero;
  logic ramp_last;
  logic above_level;
  logic inside_band;
  logic dev_neg;
  logic spd_neg;
  logic delay_over;
  logic ramp_over;
  logic [15:0] spd_abs;
  logic [31:0] freq_mag;
  logic [31:0] dev_mag;
  logic [31:0] spd_mag;
  logic [31:0] measure;
  logic [31:0] level_w;
  logic [31:0] hyst_w;
  logic [32:0] meas_plus_hyst;
  logic [11:0] delay_c;
  logic [11:0] ramp_c;
  logic [15:0] first_grp [`SGS_LANES];
  logic [15:0] second_grp [`SGS_LANES];
  logic [15:0] gain_now [`SGS_LANES];

  sgs_ms_tick #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tick (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .tick_o(ms_tick)
  );

  assign first_grp[`SGS_LANE_SPEED] = SPEED_GAIN_1_I;
  assign first_grp[`SGS_LANE_INTEG] = INTEGRAL_TIME_1_I;
  assign first_grp[`SGS_LANE_FILTER] = TORQUE_FILTER_1_I;
  assign first_grp[`SGS_LANE_POS] = POSITION_GAIN_1_I;
  assign second_grp[`SGS_LANE_SPEED] = SPEED_GAIN_2_I;
  assign second_grp[`SGS_LANE_INTEG] = SECOND_INTEGRAL_TIME_I;
  assign second_grp[`SGS_LANE_FILTER] = TORQUE_FILTER_2_I;
  assign second_grp[`SGS_LANE_POS] = POSITION_GAIN_2_I;

  // Delay and ramp settings above their range are held at the limit
  assign delay_over = SWITCH_QUALIFY_DELAY_I > `SGS_TIME_MAX;
  assign ramp_over = SWITCH_RAMP_TIME_I > `SGS_TIME_MAX;
  assign delay_c = delay_over ? `SGS_TIME_MAX : SWITCH_QUALIFY_DELAY_I;
  assign ramp_c = ramp_over ? `SGS_TIME_MAX : SWITCH_RAMP_TIME_I;
  // a zero ramp time applies the target group at once
  assign ramp_zero = ramp_c == 12'h000;

  // command pulse frequency in 0.1 kpps, never negative
  assign freq_mag = {16'h0000, CMD_PULSE_FREQ_I};
  assign dev_neg = POS_DEVIATION_I[31];
  assign dev_mag = dev_neg ? 32'(-POS_DEVIATION_I) : POS_DEVIATION_I;
  assign spd_neg = MOTOR_SPEED_I[15];
  assign spd_abs = spd_neg ? 16'(-MOTOR_SPEED_I) : MOTOR_SPEED_I;
  assign spd_mag = {16'h0000, spd_abs};

  // Measured quantity of the active comparison mode
  always_comb begin
    unique case (GAIN_SWITCH_SELECT_I)
      `SGS_SEL_FREQ: begin
        measure = freq_mag;
      end
      `SGS_SEL_DEVIATION: begin
        measure = dev_mag;
      end
      `SGS_SEL_SPEED: begin
        measure = spd_mag;
      end
      default: begin
        measure = 32'h00000000;
      end
    endcase
  end

  // Level and hysteresis widened to the measure
  assign level_w = {17'h00000, SWITCH_THRESHOLD_LEVEL_I};
  assign hyst_w = {17'h00000, SWITCH_HYSTERESIS_I};
  // one level for all comparison modes
  assign above_level = measure > level_w;
  assign meas_plus_hyst = {1'b0, measure} + {1'b0, hyst_w};
  assign inside_band = meas_plus_hyst >= {1'b0, level_w};
  // enter above the level, stay while inside the band
  assign cmp_want = s_r.grp ? inside_band : above_level;

  // Group wanted by the active condition
  always_comb begin
    unique case (GAIN_SWITCH_SELECT_I)
      `SGS_SEL_FIXED_FIRST: begin
        want = 1'b0;
      end
      `SGS_SEL_FIXED_SECOND: begin
        want = 1'b1;
      end
      `SGS_SEL_INPUT: begin
        want = GROUP_SELECT_INPUT_I;
      end
      `SGS_SEL_FREQ,
      `SGS_SEL_DEVIATION,
      `SGS_SEL_SPEED: begin
        want = cmp_want;
      end
      // Codes 6 and 7 behave as the fixed first group
      default: begin
        want = 1'b0;
      end
    endcase
  end

  // leaving the condition also makes a pending change
  assign pending = want != s_r.grp;
  // change only after the condition has held long enough
  assign qualified = pending && (s_r.qual_cnt >= delay_c);
  assign qual_step = ms_tick && (s_r.qual_cnt < delay_c);
  assign ramp_last = (s_r.elapsed + 12'h001) >= s_r.total;

  always_comb begin
    s_nxt = s_r;
    s_nxt.load = 1'b0;
    s_nxt.cond = want;
    // persistence counter restarts whenever the condition drops
    if (!pending) begin
      s_nxt.qual_cnt = 12'h000;
    end else if (qual_step) begin
      s_nxt.qual_cnt = s_r.qual_cnt + 12'h001;
    end
    if (qualified) begin
      // new ramp starts from wherever the gains are now
      s_nxt.grp = want;
      s_nxt.load = 1'b1;
      s_nxt.qual_cnt = 12'h000;
      s_nxt.elapsed = 12'h000;
      s_nxt.total = ramp_c;
      s_nxt.st = ramp_zero ? sgs_pkg::ST_STEADY : sgs_pkg::ST_RAMP;
    end else begin
      unique case (s_r.st)
        sgs_pkg::ST_STEADY: begin
          // Start qualifying as soon as another group is wanted
          s_nxt.st = pending ? sgs_pkg::ST_QUAL : sgs_pkg::ST_STEADY;
        end
        sgs_pkg::ST_QUAL: begin
          // A dropped condition abandons the change
          s_nxt.st = pending ? sgs_pkg::ST_QUAL : sgs_pkg::ST_STEADY;
        end
        sgs_pkg::ST_RAMP: begin
          if (ms_tick) begin
            if (ramp_last) begin
              s_nxt.elapsed = s_r.total;
              s_nxt.st = pending ? sgs_pkg::ST_QUAL : sgs_pkg::ST_STEADY;
            end else begin
              s_nxt.elapsed = s_r.elapsed + 12'h001;
            end
          end
        end
        default: s_nxt.st = sgs_pkg::ST_STEADY;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // one load, one timebase and one target for every lane
  assign ramp.load = s_r.load;
  assign ramp.ramping = s_r.st == sgs_pkg::ST_RAMP;
  assign ramp.grp = s_r.grp;
  assign ramp.elapsed = s_r.elapsed;
  assign ramp.total = s_r.total;

  // every lane shares one ramp timebase
  for (genvar i = 0; i < `SGS_LANES; i++) begin : g_lane
    sgs_ramp_lane u_lane (
      .clk_i(CORE_CLK_I),
      .rst_i(SYS_RST_I),
      .ramp(ramp),
      .first_i(first_grp[i]),
      .second_i(second_grp[i]),
      .value_o(gain_now[i])
    );
  end

  // one lane per gain of the group
  assign SPEED_GAIN_O = gain_now[`SGS_LANE_SPEED];
  assign INTEGRAL_TIME_O = gain_now[`SGS_LANE_INTEG];
  assign TORQUE_FILTER_O = gain_now[`SGS_LANE_FILTER];
  assign POSITION_GAIN_O = gain_now[`SGS_LANE_POS];
  // maximum integral time cancels the integral term
  assign INTEGRAL_CANCEL_O = gain_now[`SGS_LANE_INTEG] >= `SGS_INTEG_MAX;

  // group now in force, first or second
  assign ACTIVE_GROUP_O = s_r.grp;
  // condition seen but not yet qualified
  assign SWITCH_PENDING_O = s_r.st == sgs_pkg::ST_QUAL;
  // gains still moving toward the target
  assign RAMP_BUSY_O = s_r.st == sgs_pkg::ST_RAMP;
  // Wanted group, one cycle late
  assign CONDITION_MET_O = s_r.cond;
endmodule

`default_nettype wire

/* File: design/sgs_ms_tick.sv */
// Millisecond enable pulse divider
`timescale 1ns/1ps
`default_nettype none

module sgs_ms_tick #(
  parameter int MS_CYCLES = 10000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  sgs_pkg::sgs_tick_t s_r;
  sgs_pkg::sgs_tick_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt >= 16'(MS_CYCLES - 1)) begin
      s_nxt.cnt = 16'h0000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_o = s_r.tick;
endmodule

`default_nettype wire

/* File: design/sgs_pkg.sv */
// Types of the servo gain group switcher
package sgs_pkg;

  typedef enum logic [1:0] {
    ST_STEADY = 2'b00,
    ST_QUAL = 2'b01,
    ST_RAMP = 2'b10
  } sgs_state_t;

  typedef struct packed {
    sgs_state_t st;
    logic grp;
    logic load;
    logic cond;
    logic [11:0] qual_cnt;
    logic [11:0] elapsed;
    logic [11:0] total;
  } sgs_ctl_t;

  typedef struct packed {
    logic [15:0] start;
    logic [15:0] out;
  } sgs_lane_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } sgs_tick_t;

endpackage

/* File: design/sgs_ramp_if.sv */
// Ramp control carried from the switch controller to the gain lanes
`timescale 1ns/1ps
`default_nettype none

interface sgs_ramp_if;
  logic load;
  logic ramping;
  logic grp;
  logic [11:0] elapsed;
  logic [11:0] total;

  modport ctrl (
    output load,
    output ramping,
    output grp,
    output elapsed,
    output total
  );

  modport lane (
    input load,
    input ramping,
    input grp,
    input elapsed,
    input total
  );
endinterface

`default_nettype wire

/* File: design/sgs_ramp_lane.sv */
// One gain value moved linearly between its two group settings
`timescale 1ns/1ps
`default_nettype none

module sgs_ramp_lane (
  input wire logic clk_i,
  input wire logic rst_i,
  sgs_ramp_if.lane ramp,
  input wire logic [15:0] first_i,
  input wire logic [15:0] second_i,
  output logic [15:0] value_o
);
  sgs_pkg::sgs_lane_t s_r;
  sgs_pkg::sgs_lane_t s_nxt;
  logic [15:0] target;
  logic signed [16:0] delta;
  logic signed [29:0] prod;
  logic signed [29:0] quo;
  logic signed [17:0] sum;

  always_comb begin
    s_nxt = s_r;
    target = ramp.grp ? second_i : first_i;
    delta = $signed({1'b0, target}) - $signed({1'b0, s_r.start});
    prod = delta * $signed({1'b0, ramp.elapsed});
    quo = 30'sh0;
    sum = 18'sh0;
    if (ramp.load) begin
      // Freeze and take the present value as the ramp origin
      s_nxt.start = s_r.out;
    end else if (ramp.ramping && ramp.total != 12'h000) begin
      quo = prod / $signed({18'h00000, ramp.total});
      sum = $signed({2'b00, s_r.start}) + quo[17:0];
      s_nxt.out = sum[15:0];
    end else begin
      s_nxt.out = target;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign value_o = s_r.out;
endmodule

`default_nettype wire

/* File: tb/sgs_gain_switch_chk.sv */
// Port assertions for the gain group switcher
`timescale 1ns/1ps
`default_nettype none
`include "sgs_consts.svh"

module sgs_gain_switch_chk #(
  parameter int MS_CYCLES = `SGS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  // Settings and group inputs
  input wire logic [2:0] GAIN_SWITCH_SELECT_I,
  input wire logic [11:0] SWITCH_QUALIFY_DELAY_I,
  input wire logic GROUP_SELECT_INPUT_I,
  input wire logic [15:0] SPEED_GAIN_1_I,
  input wire logic [15:0] POSITION_GAIN_2_I,
  // Applied gains and status
  input wire logic [15:0] SPEED_GAIN_O,
  input wire logic [15:0] POSITION_GAIN_O,
  input wire logic [15:0] INTEGRAL_TIME_O,
  input wire logic INTEGRAL_CANCEL_O,
  input wire logic ACTIVE_GROUP_O,
  input wire logic SWITCH_PENDING_O,
  input wire logic RAMP_BUSY_O
);
  logic [31:0] busy_cnt_r;
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  // Length of the current ramp in cycles
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || !RAMP_BUSY_O || $changed(ACTIVE_GROUP_O))
      busy_cnt_r <= '0;
    else
      busy_cnt_r <= busy_cnt_r + 32'h1;
  end

  chk_first_fixed: assert property (
    (GAIN_SWITCH_SELECT_I == 3'h0)[*3] ##0 !ACTIVE_GROUP_O |=> !ACTIVE_GROUP_O)
    else $error("first group left in fixed mode");
  chk_second_fixed: assert property (
    (GAIN_SWITCH_SELECT_I == 3'h1)[*3] ##0 ACTIVE_GROUP_O |=> ACTIVE_GROUP_O)
    else $error("second group left in fixed mode");
  chk_input_off: assert property (
    (GAIN_SWITCH_SELECT_I == 3'h2 && !GROUP_SELECT_INPUT_I)[*3]
    ##0 !ACTIVE_GROUP_O |=> !ACTIVE_GROUP_O)
    else $error("group input off but second group taken");
  chk_ramp_cause: assert property (
    $rose(RAMP_BUSY_O) |-> ACTIVE_GROUP_O != $past(ACTIVE_GROUP_O))
    else $error("ramp started without a group change");
  chk_pending_first: assert property (
    $changed(ACTIVE_GROUP_O) && !$past(RAMP_BUSY_O)
    && $past(SWITCH_QUALIFY_DELAY_I) != 12'h000 |-> $past(SWITCH_PENDING_O))
    else $error("group changed without qualifying first");
  chk_cancel_flag: assert property (
    INTEGRAL_CANCEL_O == (INTEGRAL_TIME_O >= `SGS_INTEG_MAX))
    else $error("integral cancel flag wrong");
  chk_follow_first: assert property (
    !ACTIVE_GROUP_O && !$past(ACTIVE_GROUP_O) && !RAMP_BUSY_O
    && !$past(RAMP_BUSY_O) |=> SPEED_GAIN_O == $past(SPEED_GAIN_1_I))
    else $error("speed gain not from first group");
  chk_follow_second: assert property (
    ACTIVE_GROUP_O && $past(ACTIVE_GROUP_O) && !RAMP_BUSY_O
    && !$past(RAMP_BUSY_O) |=> POSITION_GAIN_O == $past(POSITION_GAIN_2_I))
    else $error("position gain not from second group");
  chk_ramp_bound: assert property (
    busy_cnt_r <= 32'hbba * 32'(MS_CYCLES))
    else $error("ramp longer than the time limit");
endmodule

bind sgs_gain_switch sgs_gain_switch_chk #(.MS_CYCLES(MS_CYCLES)) chk_u (
  .CORE_CLK_I(CORE_CLK_I),
  .SYS_RST_I(SYS_RST_I),
  .GAIN_SWITCH_SELECT_I(GAIN_SWITCH_SELECT_I),
  .SWITCH_QUALIFY_DELAY_I(SWITCH_QUALIFY_DELAY_I),
  .GROUP_SELECT_INPUT_I(GROUP_SELECT_INPUT_I),
  .SPEED_GAIN_1_I(SPEED_GAIN_1_I),
  .POSITION_GAIN_2_I(POSITION_GAIN_2_I),
  .SPEED_GAIN_O(SPEED_GAIN_O),
  .POSITION_GAIN_O(POSITION_GAIN_O),
  .INTEGRAL_TIME_O(INTEGRAL_TIME_O),
  .INTEGRAL_CANCEL_O(INTEGRAL_CANCEL_O),
  .ACTIVE_GROUP_O(ACTIVE_GROUP_O),
  .SWITCH_PENDING_O(SWITCH_PENDING_O),
  .RAMP_BUSY_O(RAMP_BUSY_O)
);

`default_nettype wire

/* File: tb/sgs_gain_switch_tb_top.sv */
// Self-checking bench for the gain group switcher
`timescale 1ns/1ps
`default_nettype none

module sgs_gain_switch_tb_top;
  logic clk, rst, gsi, cancel, act, pend, busy, met;
  logic [2:0] sel;
  logic [14:0] lvl, hys;
  logic [11:0] dly, rmp;
  logic [15:0] meas, freq;
  logic signed [31:0] dev;
  logic signed [15:0] spd;
  logic [15:0] g [8];
  logic [15:0] q [4];
  int err_count, compares, cyc;

  sgs_loop_model loop_u (.clk_i(clk), .meas_i(meas), .freq_o(freq),
    .dev_o(dev), .speed_o(spd));

  sgs_gain_switch #(.MS_CYCLES(10)) dut_u (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .GAIN_SWITCH_SELECT_I(sel),
    .SWITCH_THRESHOLD_LEVEL_I(lvl), .SWITCH_HYSTERESIS_I(hys),
    .SWITCH_QUALIFY_DELAY_I(dly), .SWITCH_RAMP_TIME_I(rmp),
    .GROUP_SELECT_INPUT_I(gsi), .CMD_PULSE_FREQ_I(freq),
    .POS_DEVIATION_I(dev), .MOTOR_SPEED_I(spd),
    .SPEED_GAIN_1_I(g[0]), .INTEGRAL_TIME_1_I(g[1]),
    .TORQUE_FILTER_1_I(g[2]), .POSITION_GAIN_1_I(g[3]),
    .SPEED_GAIN_2_I(g[4]), .SECOND_INTEGRAL_TIME_I(g[5]),
    .TORQUE_FILTER_2_I(g[6]), .POSITION_GAIN_2_I(g[7]),
    .SPEED_GAIN_O(q[0]), .INTEGRAL_TIME_O(q[1]), .TORQUE_FILTER_O(q[2]),
    .POSITION_GAIN_O(q[3]), .INTEGRAL_CANCEL_O(cancel),
    .ACTIVE_GROUP_O(act), .SWITCH_PENDING_O(pend), .RAMP_BUSY_O(busy),
    .CONDITION_MET_O(met));

  task automatic final_report();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Strict range check: lo < got < hi
  task automatic rng(input logic [15:0] lo, hi, got);
    compares++;
    if ((got > lo && got < hi) !== 1'b1) begin
      err_count++;
      $display("mismatch t=%0t exp=%h..%h got=%h", $time, lo, hi, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic s_fixed();
    gsi = 1'b1;
    meas = 16'h7fff;
    wt(20);
    cmp(16'h0, {15'h0, act});
    cmp(g[0], q[0]);
    sel = 3'h1;
    gsi = 1'b0;
    meas = 16'h0000;
    wt(20);
    cmp(16'h1, {15'h0, act});
    for (int i = 0; i < 4; i++) cmp(g[i+4], q[i]);
    cmp(16'h1, {15'h0, cancel});
  endtask

  task automatic s_input();
    sel = 3'h2;
    wt(10);
    cmp(16'h0, {15'h0, act});
    gsi = 1'b1;
    wt(10);
    cmp(16'h1, {15'h0, act});
    gsi = 1'b0;
    wt(10);
    cmp(16'h0, {15'h0, act});
  endtask

  task automatic s_cmp();
    for (int m = 3; m <= 5; m++) begin
      sel = 3'(m);
      meas = 16'h0064;
      wt(10);
      cmp(16'h0, {15'h0, act});
      meas = 16'h0065;
      wt(10);
      cmp(16'h1, {15'h0, act});
      meas = 16'h005f;
      wt(10);
      cmp(16'h1, {15'h0, act});
      meas = 16'h005e;
      wt(10);
      cmp(16'h0, {15'h0, act});
    end
  endtask

  task automatic s_timing();
    int n;
    sel = 3'h2;
    dly = 12'h002;
    rmp = 12'h004;
    wt(40);
    gsi = 1'b1;
    wt(5);
    cmp(16'h1, {15'h0, pend});
    cmp(16'h1, {15'h0, met});
    gsi = 1'b0;
    wt(40);
    cmp(16'h0, {15'h0, act});
    cmp(16'h0, {15'h0, pend});
    cmp(16'h0, {15'h0, met});
    gsi = 1'b1;
    n = 0;
    while (act !== 1'b1 && n < 100) begin
      wt(1);
      n++;
    end
    rng(16'h0008, 16'h0022, 16'(n));
    wt(21);
    rng(g[0], g[4], q[0]);
    rng(g[3], g[7], q[3]);
    n = 21;
    while (busy === 1'b1 && n < 100) begin
      wt(1);
      n++;
    end
    rng(16'h001d, 16'h002c, 16'(n));
    wt(2);
    for (int i = 0; i < 4; i++) cmp(g[i+4], q[i]);
    gsi = 1'b0;
    wt(120);
    cmp(g[1], q[1]);
    cmp(16'h0, {15'h0, cancel});
  endtask

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    sel = 3'h0;
    lvl = 15'h0064;
    hys = 15'h0005;
    dly = 12'h000;
    rmp = 12'h000;
    gsi = 1'b0;
    meas = 16'h0000;
    g = '{16'h0100, 16'h0040, 16'h0010, 16'h0020,
      16'h0500, 16'h2710, 16'h0030, 16'h0060};
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    wt(2);
    s_fixed();
    s_input();
    s_cmp();
    s_timing();
    final_report();
  end
endmodule

`default_nettype wire

/* File: tb/sgs_loop_model.sv */
// Servo loop stand-in that reports measured quantities to the switcher
`timescale 1ns/1ps
`default_nettype none

module sgs_loop_model (
  // Clock and demand
  input wire logic clk_i,
  input wire logic [15:0] meas_i,
  // Measured quantities
  output logic [15:0] freq_o,
  output logic signed [31:0] dev_o,
  output logic signed [15:0] speed_o
);
  // Measures lag the demand by one control cycle
  always_ff @(posedge clk_i) begin
    freq_o <= meas_i;
    dev_o <= $signed({16'h0000, meas_i});
    speed_o <= $signed(meas_i);
  end
endmodule

`default_nettype wire
